//--- logic/gpt_master_flow.sv
// Graphics master data flow control: write start, read throttling and the
// ready pin, with a throttle point tracker. Assumes all bus pins are
// sampled on clk_sys, the common bus clock, so they need no synchroniser.
//
// How it works
// - Either side stalls by withholding ready
// - Next block two clocks after both ready
// - Both ready at point means no idle
// - First point two clocks after block start
// - Later points four clocks after completion
// - Ready ignored between points and lone blocks
// - Drive ready throughout every read throttle point
// - Drive deasserted one clock before release
// - Long transfers may drive ready early
// - Master never stalls started write data
// - Write block follows two clocks after target
// - Write ready pulse, then deassert and release
// - Read points driven, released after each
// - Write pulse one or two clocks after grant
// - Receiver asserts flow control on its own
// - Asserted ready holds until point completes
// - Codes 000 and 001 return read data
// - Codes 010 and 011 request write data
// - Block is four clocks: 16, 32 or 64 bytes by mode
`timescale 1ns/1ns
`default_nettype none
module gpt_master_flow #(
    parameter int DATA_W   = 32,
    parameter int WR_DELAY = 1
) (
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    input  wire logic                      gnt_n,
    input  wire logic [2:0]                grant_status_code,
    input  wire logic                      target_ready_n,
    output logic                           master_ready_n_out,
    output logic                           master_ready_n_oe,
    output logic                           read_buffer_full_n,
    input  wire logic [DATA_W-1:0]         ad_in,
    output logic [DATA_W-1:0]              ad_out,
    output logic                           ad_oe,
    input  wire logic [1:0]                xfer_mode,
    input  wire logic [gpt_pkg::LEN_W-1:0] rd_len_bytes,
    output logic                           rd_len_take,
    input  wire logic [gpt_pkg::LEN_W-1:0] wr_len_bytes,
    output logic                           wr_len_take,
    input  wire logic [DATA_W-1:0]         wr_data,
    output logic                           wr_data_take,
    output logic [DATA_W-1:0]              rd_data,
    output logic                           rd_valid,
    output logic                           rd_high_pri,
    input  wire logic                      rd_hold,
    input  wire logic                      rd_buf_full
);
    import gpt_pkg::*;

    // Refused at elaboration: the start rule allows only one or two clocks
    if (WR_DELAY < WR_DELAY_MIN || WR_DELAY > WR_DELAY_MAX) begin : g_bad_delay
        $error("WR_DELAY must be 1 or 2");
    end
    if (DATA_W < 1) begin : g_bad_width
        $error("DATA_W must be positive");
    end

    localparam logic [1:0] WR_DLY_LAST = 2'(WR_DELAY - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Byte count to data clocks for the current transfer mode
    function automatic logic [LEN_W-1:0] bytes_to_clks(
        input logic [LEN_W-1:0] bytes,
        input logic [1:0]       mode
    );
        logic [LEN_W-1:0] per_clk;
        logic [LEN_W:0]   sum;
        per_clk = LEN_W'(BYTES_PER_CLK_1X);
        if (mode == MODE_2X) begin
            per_clk = LEN_W'(BLK_BYTES_2X / BLOCK_CLKS);
        end else if (mode == MODE_4X) begin
            per_clk = LEN_W'(BLK_BYTES_4X / BLOCK_CLKS);
        end
        sum = {1'b0, bytes} + {1'b0, per_clk} - (LEN_W + 1)'(1);
        bytes_to_clks = LEN_W'(sum / {1'b0, per_clk});
        if (bytes_to_clks == '0) begin
            bytes_to_clks = LEN_W'(1);
        end
    endfunction : bytes_to_clks

    ////////////////////////////////////////////////////////////////////////////
    // Status classes share one decode; priority sits in bit 0 only
    function automatic logic is_read_code(
        input logic [2:0] code
    );
        is_read_code = (code[2:1] == ST_LP_READ[2:1]);
    endfunction : is_read_code

    function automatic logic is_write_code(
        input logic [2:0] code
    );
        is_write_code = (code[2:1] == ST_LP_WRITE[2:1]);
    endfunction : is_write_code

    gpt_thr_if thr ();

    gpt_tracker u_tracker (
        .clk_sys (clk_sys),
        .reset   (reset),
        .thr     (thr)
    );

    logic       grant_take;
    logic       grant_write;
    logic       tgt_rdy;
    logic       pend_valid_reg;
    logic       pend_write_reg;
    logic       pend_high_reg;
    logic [1:0] dly_reg;
    logic       wr_fire;
    logic       rd_fire;
    logic       cur_write_reg;
    logic       wr_now;
    logic       mr_tp;
    logic       mr_assert_rd;
    logic       hold_reg;
    logic       park_reg;
    logic       pre_drive;

    ////////////////////////////////////////////////////////////////////////////
    // Grant decode
    assign tgt_rdy     = (target_ready_n == READY_ON);
    assign grant_take  = !gnt_n && (is_read_code(grant_status_code) ||
                                    is_write_code(grant_status_code));
    assign grant_write = is_write_code(grant_status_code);

    // One grant waits while the bus is busy; a pipelined grant behind it is
    // not queued further, so the arbiter must not stack more than one.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pend_valid_reg <= 1'b0;
            pend_write_reg <= 1'b0;
            pend_high_reg  <= 1'b0;
        end else if (grant_take && (!pend_valid_reg || wr_fire || rd_fire)) begin
            pend_valid_reg <= 1'b1;
            pend_write_reg <= grant_write;
            pend_high_reg  <= grant_status_code[0];
        end else if (wr_fire || rd_fire) begin
            pend_valid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Starting a transaction
    // Write starts a fixed one or two clocks after the grant or the bus frees
    assign wr_fire = pend_valid_reg && pend_write_reg && !thr.busy &&
                     (dly_reg == WR_DLY_LAST);
    // Read starts on the target's initial ready pulse
    assign rd_fire = pend_valid_reg && !pend_write_reg && !thr.busy && tgt_rdy;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dly_reg <= 2'h0;
        end else if (wr_fire || !pend_valid_reg || !pend_write_reg || thr.busy) begin
            dly_reg <= 2'h0;
        end else begin
            dly_reg <= dly_reg + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cur_write_reg <= 1'b0;
        end else if (wr_fire) begin
            cur_write_reg <= 1'b1;
        end else if (rd_fire) begin
            cur_write_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_high_pri <= 1'b0;
        end else if (rd_fire) begin
            rd_high_pri <= pend_high_reg;
        end
    end

    assign thr.start   = wr_fire | rd_fire;
    assign thr.len_clk = wr_fire ? bytes_to_clks(wr_len_bytes, xfer_mode)
                                 : bytes_to_clks(rd_len_bytes, xfer_mode);
    assign wr_len_take = wr_fire;
    assign rd_len_take = rd_fire;
    assign wr_now      = wr_fire | (cur_write_reg & !rd_fire);

    ////////////////////////////////////////////////////////////////////////////
    // Ready handling at throttle points
    // Writes: the master never joins a point, so only the target decides
    assign mr_tp        = thr.tp_active & !cur_write_reg;
    // Read ready is chosen from own buffer state only, then held once shown
    assign mr_assert_rd = mr_tp & (hold_reg | !rd_hold);
    // Outside a point the ready values do not matter; the tracker ignores them
    assign thr.ready_both = tgt_rdy & (cur_write_reg | mr_assert_rd);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_reg <= 1'b0;
        end else begin
            hold_reg <= mr_assert_rd & !thr.tp_done;
        end
    end

    // One clock of driven deassert after each write pulse or completed read point, since
    // the pin is a sustained tri-state line held by a pull-up
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            park_reg <= 1'b0;
        end else begin
            park_reg <= wr_fire | (mr_tp & thr.tp_done);
        end
    end

    assign pre_drive = thr.pre_tp & !cur_write_reg & !thr.start;

    assign master_ready_n_oe  = wr_fire | park_reg | mr_tp | pre_drive;
    assign master_ready_n_out = (wr_fire | mr_assert_rd) ? READY_ON : READY_OFF;

    ////////////////////////////////////////////////////////////////////////////
    // Data path
    // During write waits the bus keeps the offered word; any value is legal
    assign ad_oe        = wr_now & (thr.busy | wr_fire);
    assign ad_out       = wr_data;
    assign wr_data_take = thr.data_en & wr_now;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= thr.data_en & !wr_now;
        end
    end

    // Word is held between reads so a slow consumer still sees it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_data <= '0;
        end else if (thr.data_en && !wr_now) begin
            rd_data <= ad_in;
        end
    end

    // Buffer-full follows the local buffer only, never the target's ready
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            read_buffer_full_n <= RBF_RST_VAL;
        end else begin
            read_buffer_full_n <= !rd_buf_full;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_write_start: assert property (@(posedge clk_sys) disable iff (reset)
        grant_take && grant_write && !pend_valid_reg && !thr.busy
        |-> ##WR_DELAY wr_fire)
        else $error("Write ready pulse not at the set delay");
    a_write_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        wr_fire |=> master_ready_n_oe && master_ready_n_out == READY_OFF
                    ##1 !master_ready_n_oe)
        else $error("Write ready not parked and released");
    a_write_no_tp: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_active && cur_write_reg |-> master_ready_n_out == READY_OFF)
        else $error("Master joined a write throttle point");
    a_tp_driven: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_active && !cur_write_reg |-> master_ready_n_oe)
        else $error("Ready not driven during a read point");
    a_ready_hold: assert property (@(posedge clk_sys) disable iff (reset)
        mr_assert_rd && !thr.tp_done |=> master_ready_n_out == READY_ON)
        else $error("Ready withdrawn inside a point");
    a_read_park: assert property (@(posedge clk_sys) disable iff (reset)
        mr_tp && thr.tp_done |=> master_ready_n_oe && master_ready_n_out == READY_OFF
                                 ##1 !master_ready_n_oe)
        else $error("Read ready not parked after a point");
    a_next_point: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_done && !thr.last |-> ##1 !thr.tp_active [*3])
        else $error("Point came sooner than four clocks");
    a_rbf_local: assert property (@(posedge clk_sys) disable iff (reset)
        !$past(reset) |-> read_buffer_full_n == !$past(rd_buf_full))
        else $error("Buffer-full did not follow local state");
    a_write_data: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_done && cur_write_reg |-> ##2 wr_data_take)
        else $error("Write block late after target ready");
    a_read_start: assert property (@(posedge clk_sys) disable iff (reset)
        rd_fire |-> thr.data_en && !ad_oe)
        else $error("Read start without data clock");
    a_park_first: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(master_ready_n_oe) |-> $past(master_ready_n_out) == READY_OFF)
        else $error("Ready released without a driven deassert");
    a_write_bus: assert property (@(posedge clk_sys) disable iff (reset)
        wr_data_take |-> ad_oe)
        else $error("Write data clock with the bus not driven");
    a_early_drive: assert property (@(posedge clk_sys) disable iff (reset)
        pre_drive |-> master_ready_n_oe && master_ready_n_out == READY_OFF)
        else $error("Early ready drive not deasserted");
    a_point_inside: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_active |-> thr.busy || thr.start)
        else $error("Point outside a transaction");

endmodule : gpt_master_flow
`default_nettype wire

//--- logic/gpt_pkg.sv
// Shared constants and types for the graphics port block throttle logic.
// Assumes every party samples the bus signals on the common 1x bus clock.
package gpt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Grant status codes
    localparam logic [2:0] ST_LP_READ  = 3'h0;
    localparam logic [2:0] ST_HP_READ  = 3'h1;
    localparam logic [2:0] ST_LP_WRITE = 3'h2;
    localparam logic [2:0] ST_HP_WRITE = 3'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer modes and block size
    localparam logic [1:0] MODE_1X = 2'h0;
    localparam logic [1:0] MODE_2X = 2'h1;
    localparam logic [1:0] MODE_4X = 2'h2;
    localparam int BYTES_PER_CLK_1X = 4;
    localparam int BYTES_PER_CLK_2X = 8;
    localparam int BYTES_PER_CLK_4X = 16;
    localparam int BLK_BYTES_2X     = 32;
    localparam int BLK_BYTES_4X     = 64;
    localparam int BLOCK_CLKS       = BLK_BYTES_2X / BYTES_PER_CLK_2X;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts in 1x clocks
    localparam int TP_OFFSET_CLKS = 2;
    localparam int RESUME_CLKS    = 2;
    localparam int TP_REPEAT_CLKS = 4;
    localparam int WR_DELAY_MIN   = 1;
    localparam int WR_DELAY_MAX   = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Widths, levels and reset values
    localparam int   LEN_W       = 12;
    localparam logic READY_ON    = 1'b0;
    localparam logic READY_OFF   = 1'b1;
    localparam logic RBF_RST_VAL = 1'b1;

    typedef enum logic [2:0] {
        GPT_IDLE = 3'b001,
        GPT_XFER = 3'b010,
        GPT_WAIT = 3'b100
    } gpt_trk_state_e;

endpackage : gpt_pkg

//--- logic/gpt_thr_if.sv
// Carrier between the master flow control and its throttle point tracker.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface gpt_thr_if;
    import gpt_pkg::*;
    logic             start;
    logic [LEN_W-1:0] len_clk;
    logic             ready_both;
    logic             data_en;
    logic             last;
    logic             busy;
    logic             tp_active;
    logic             tp_done;
    logic             pre_tp;

    modport ctl (output start, output len_clk, output ready_both,
                 input data_en, input last, input busy, input tp_active,
                 input tp_done, input pre_tp);
    modport trk (input start, input len_clk, input ready_both,
                 output data_en, output last, output busy, output tp_active,
                 output tp_done, output pre_tp);
endinterface : gpt_thr_if
`default_nettype wire

//--- logic/gpt_tracker.sv
// Throttle point tracker: counts data clocks of one transaction and places
// throttle points two clocks into each block but the last. Assumes start only while idle.
`timescale 1ns/1ns
`default_nettype none
module gpt_tracker (
    input wire logic clk_sys,
    input wire logic reset,
    gpt_thr_if.trk   thr
);
    import gpt_pkg::*;

    localparam logic [1:0]       TP_POS   = 2'(TP_OFFSET_CLKS);
    localparam logic [1:0]       PRE_POS  = 2'(TP_OFFSET_CLKS - 1);
    localparam logic [1:0]       END_POS  = 2'(BLOCK_CLKS - 1);
    localparam logic [LEN_W-1:0] BLK_TAIL = LEN_W'(BLOCK_CLKS - TP_OFFSET_CLKS);

    gpt_trk_state_e   state_reg;
    logic [LEN_W-1:0] rem_reg;
    logic [1:0]       pos_reg;
    logic             tp_open_reg;
    logic [LEN_W-1:0] cur_rem;
    logic [1:0]       cur_pos;
    logic             in_data;
    logic             tp_here;

    ////////////////////////////////////////////////////////////////////////////
    // Current position, with the start cycle counted as the first data clock
    assign cur_rem = thr.start ? thr.len_clk : rem_reg;
    assign cur_pos = thr.start ? 2'h0 : pos_reg;
    assign in_data = thr.start | (state_reg == GPT_XFER);
    // A point exists only when data follows this block; none on a lone block
    assign tp_here = in_data && (cur_pos == TP_POS) && (cur_rem > BLK_TAIL);
    assign thr.tp_active = tp_here | tp_open_reg;
    assign thr.tp_done   = thr.tp_active & thr.ready_both;
    assign thr.data_en   = in_data;
    assign thr.last      = in_data && (cur_rem == LEN_W'(1));
    assign thr.busy      = (state_reg != GPT_IDLE);
    assign thr.pre_tp    = in_data && (cur_pos == PRE_POS) && (cur_rem > LEN_W'(BLOCK_CLKS - 1));

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tp_open_reg <= 1'b0;
        end else if (thr.tp_done) begin
            tp_open_reg <= 1'b0;
        end else if (tp_here) begin
            tp_open_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rem_reg <= '0;
            pos_reg <= 2'h0;
        end else if (in_data) begin
            rem_reg <= cur_rem - LEN_W'(1);
            pos_reg <= cur_pos + 2'h1;
        end else begin
            pos_reg <= 2'h0;
        end
    end

    // An unfinished point turns into idle clocks; resume two clocks after it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= GPT_IDLE;
        end else if (in_data) begin
            if (thr.last) begin
                state_reg <= GPT_IDLE;
            end else if (cur_pos == END_POS && tp_open_reg) begin
                state_reg <= GPT_WAIT;
            end else begin
                state_reg <= GPT_XFER;
            end
        end else if (state_reg == GPT_WAIT && !tp_open_reg) begin
            state_reg <= GPT_XFER;
        end
    end

    a_resume_two: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_done |-> ##RESUME_CLKS thr.data_en)
        else $error("Block did not resume two clocks after point");
    a_stall_gap: assert property (@(posedge clk_sys) disable iff (reset)
        thr.tp_active && !thr.ready_both |-> ##2 !thr.data_en)
        else $error("Data moved despite an unfinished point");
    a_first_point: assert property (@(posedge clk_sys) disable iff (reset)
        thr.start && thr.len_clk > LEN_W'(BLOCK_CLKS) |-> ##2 thr.tp_active)
        else $error("First point not two clocks after start");
    a_lone_block: assert property (@(posedge clk_sys) disable iff (reset)
        thr.start && thr.len_clk <= LEN_W'(BLOCK_CLKS) |-> !thr.tp_active [*4])
        else $error("Point seen on a single block transfer");
endmodule : gpt_tracker
`default_nettype wire

//--- sim/gpt_core_model.sv
// Core logic model: arbiter grants plus target side of the block throttle.
// Assumes the master ready pin level is resolved by the bench (pull-up).
`timescale 1ns/1ns
`default_nettype none
module gpt_core_model (
    input  wire logic        clk_sys,
    input  wire logic        master_ready_level,
    input  wire logic        master_ready_n_oe,
    input  wire logic        read_buffer_full_n,
    input  wire logic [31:0] ad_out,
    output var  logic        gnt_n = 1'b1,
    output var  logic [2:0]  grant_status_code = 3'h7,
    output var  logic        target_ready_n = 1'b1,
    output var  logic [31:0] ad_in = 32'h0000_0000
);
    logic [31:0] got [$];
    int          viol = 0;
    int          wdel = 0;
    logic        tmo = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // One transfer; stall holds target ready off for that many cycles per point
    task automatic xfer(input logic [2:0] code, input int n, input int stall,
                        input int dly, input logic [31:0] base);
        int   i, st, cyc, done_at;
        logic wr, tp, dat, m_on;
        wr = code[1];
        for (cyc = 0; cyc < 50 && code == 3'h0 && !read_buffer_full_n; cyc++)
            @(posedge clk_sys);
        if (cyc >= 50) tmo = 1'b1;
        gnt_n <= 1'b0;
        grant_status_code <= code;
        @(posedge clk_sys);
        gnt_n <= 1'b1;
        grant_status_code <= 3'h7;
        ad_in <= ~ad_in;
        i = wr;
        wdel = 0;
        if (wr) begin
            do begin
                @(posedge clk_sys);
                wdel++;
            end while (master_ready_level && wdel < 5);
            if (wdel >= 5) begin
                tmo = 1'b1;
                return;
            end
            got.push_back(ad_out);
        end else
            repeat (dly - 1) @(posedge clk_sys);
        tp = 1'b0;
        m_on = 1'b0;
        st = 0;
        done_at = -10;
        for (cyc = 0; (i < n || tp) && cyc < 200; cyc++) begin
            // Block start only two clocks after the point completes
            dat = i < n && !(i % 4 == 0 && i > 0 && (tp || cyc < done_at + 2));
            if (dat && i % 4 == 2 && i + 2 < n) begin
                tp = 1'b1;
                st = stall;
            end
            ad_in <= (dat && !wr) ? base + i : ~ad_in;
            target_ready_n <= !((dat && i == 0) || (tp && st == 0));
            @(posedge clk_sys);
            if (dat && wr) got.push_back(ad_out);
            if (dat) i++;
            if (tp && !wr && master_ready_n_oe !== 1'b1) viol++;
            if (tp && !wr && m_on && master_ready_level) viol++;
            if (tp && !wr && !master_ready_level) m_on = 1'b1;
            if (tp && st == 0 && (wr || !master_ready_level)) begin
                tp = 1'b0;
                m_on = 1'b0;
                done_at = cyc;
            end else if (st > 0)
                st--;
        end
        target_ready_n <= 1'b1;
        ad_in <= ~ad_in;
        if (cyc >= 200) tmo = 1'b1;
    endtask : xfer
endmodule : gpt_core_model
`default_nettype wire

//--- sim/test_graphics_port_block_throttle.sv
// Self-checking bench for the master flow control against the core model.
// Assumes a 10 MHz clock and the ready pin pulled up when released.
`timescale 1ns/1ns
`default_nettype none
module test_graphics_port_block_throttle;
    import gpt_pkg::*;
    localparam int WRD = 2;
    localparam int NT  = 10;
    logic [2:0] t_code [NT] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h0, 3'h2};
    int t_len [NT] = '{2, 8, 12, 9, 4, 8, 10, 5, 16, 13};
    int t_stall [NT] = '{0, 0, 2, 1, 0, 0, 3, 1, 0, 2};
    logic clk_sys, reset = 1'b1, rd_hold = 1'b0, rd_buf_full = 1'b0, hp, bf_prev;
    logic gnt_n, target_ready_n, mr_out, mr_oe, rbf_n, ad_oe, rd_valid, rd_hi, mr_lvl;
    logic rd_take, wr_take, wd_take;
    logic [2:0]  st_code;
    logic [1:0]  xfer_mode = 2'h0;
    logic [LEN_W-1:0] rd_len_bytes = '0, wr_len_bytes = '0;
    logic [31:0] ad_in, ad_out, rd_data, wr_data = 32'h0000_0000, seed = 32'h1242;
    logic [31:0] hseed = 32'h1242, rq [$];
    int bad_count = 0, n_checks = 0, takes = 0, live = 0, t;

    assign mr_lvl = mr_oe ? mr_out : 1'b1;
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    gpt_master_flow #(.DATA_W(32), .WR_DELAY(WRD)) DUT (.clk_sys(clk_sys), .reset(reset),
        .gnt_n(gnt_n), .grant_status_code(st_code), .target_ready_n(target_ready_n),
        .master_ready_n_out(mr_out), .master_ready_n_oe(mr_oe), .read_buffer_full_n(rbf_n),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .xfer_mode(xfer_mode),
        .rd_len_bytes(rd_len_bytes), .rd_len_take(rd_take), .wr_len_bytes(wr_len_bytes),
        .wr_len_take(wr_take), .wr_data(wr_data), .wr_data_take(wd_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_high_pri(rd_hi), .rd_hold(rd_hold),
        .rd_buf_full(rd_buf_full));
    gpt_core_model core (.clk_sys(clk_sys), .master_ready_level(mr_lvl),
        .master_ready_n_oe(mr_oe), .read_buffer_full_n(rbf_n), .ad_out(ad_out),
        .gnt_n(gnt_n), .grant_status_code(st_code), .target_ready_n(target_ready_n),
        .ad_in(ad_in));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Random stalls and buffer-full reach the design every cycle
    always @(posedge clk_sys) begin
        hseed = lfsr(hseed);
        rd_hold <= hseed[3];
        rd_buf_full <= hseed[5] & hseed[6];
        if (wd_take === 1'b1) begin
            wr_data <= wr_data + 32'h0000_0001;
            check(ad_oe, 1);
        end
        if (rd_valid === 1'b1) begin
            rq.push_back(rd_data);
            hp <= rd_hi;
        end
        takes += int'(rd_take === 1'b1) + int'(wr_take === 1'b1);
        if (live > 1) check(rbf_n, !bf_prev);
        bf_prev = rd_buf_full;
        live = reset ? 0 : live + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic run_one(input logic [2:0] code, input int n, input int stall, input int dly);
        int k, md, bpc;
        seed = lfsr(seed);
        md = seed[4:0] % 3;
        bpc = BYTES_PER_CLK_1X << md;
        xfer_mode <= md[1:0];
        rd_len_bytes <= LEN_W'(n * bpc - seed[7:5] % bpc);
        wr_len_bytes <= LEN_W'(n * bpc - seed[7:5] % bpc);
        wr_data <= seed;
        rq.delete();
        core.got.delete();
        takes = 0;
        @(posedge clk_sys);
        core.xfer(code, n, stall, dly, seed);
        repeat (3) @(posedge clk_sys);
        if (core.tmo) begin
            bad_count++;
            close_out;
        end
        check(mr_oe, 0);
        check(ad_oe, 0);
        check(takes, 1);
        check(core.viol, 0);
        if (code[1]) begin
            check(core.wdel, WRD);
            for (k = 0; k < n; k++) check(core.got[k], seed + k);
            check(core.got.size(), n);
        end else begin
            for (k = 0; k < n; k++) check(rq[k], seed + k);
            check(rq.size(), n);
            check(hp, code[0]);
        end
    endtask : run_one

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (t = 0; t < NT + 6; t++) begin
            if (t < NT)
                run_one(t_code[t], t_len[t], t_stall[t], 1 + t % 2);
            else begin
                seed = lfsr(seed);
                run_one(seed[2:0] & 3'h3, 1 + seed[11:8], seed[13:12] % 3, 1 + seed[14]);
            end
            $display("test %0d finished", t);
        end
        close_out;
    end
endmodule : test_graphics_port_block_throttle
`default_nettype wire
